// ==== core/sms_pkg.sv ====
// Constants shared by the chip-select operating-mode block
package sms_pkg;
   // Number of chip-select regions served
   localparam int NUM_REGIONS = 2;

   // Byte offsets of the register map
   localparam logic [9:0] OFF_MODE_ONE = 10'h124; // First region mode, RO
   localparam logic [9:0] OFF_MODE_TWO = 10'h144; // Second region mode, RO
   localparam logic [9:0] OFF_PROG_ONE = 10'h200; // First region loader
   localparam logic [9:0] OFF_PROG_TWO = 10'h204; // Second region loader
   localparam logic [9:0] OFF_STATUS = 10'h208; // Sequencer status

   // Field positions inside a mode word
   localparam int BASE_LSB = 24; // Compare value, 8 bits
   localparam int MASK_LSB = 16; // Compare enables, 8 bits
   localparam int ALIGN_LSB = 13; // Boundary split, 3 bits
   localparam int BLS_BIT = 12; // Byte-lane strobe timing
   localparam int ADV_BIT = 11; // Address-valid use
   localparam int RSVD_BIT = 10; // Reserved, kept zero
   localparam int WRBL_LSB = 7; // Write beats, 3 bits
   localparam int WRSYNC_BIT = 6; // Clocked write select
   localparam int RDBL_LSB = 3; // Read beats, 3 bits
   localparam int RDSYNC_BIT = 2; // Clocked read select
   localparam int WIDTH_LSB = 0; // Memory width, 2 bits

   // Reset value of a mode word: address valid used, 32-bit memory
   localparam logic [31:0] MODE_RESET = 32'h0000_0802;
   localparam logic [31:0] RSVD_MASK = 32'h0000_0400;

   // Field encodings
   localparam logic [2:0] BL_ONE = 3'h0; // Single beat
   localparam logic [2:0] BL_FOUR = 3'h1; // Four beats
   localparam logic [1:0] WIDTH16 = 2'h1; // 16-bit memory
   localparam logic [1:0] WIDTH32 = 2'h2; // 32-bit memory
   localparam logic [2:0] ALIGN_NONE = 3'h0; // Cross any boundary
   localparam logic [2:0] ALIGN_32 = 3'h1; // Split at 32 beats
   localparam logic [2:0] ALIGN_64 = 3'h2; // Split at 64 beats
   localparam logic [2:0] ALIGN_128 = 3'h3; // Split at 128 beats
   localparam logic [2:0] ALIGN_256 = 3'h4; // Split at 256 beats

   // Beat counts and address steps
   localparam logic [8:0] BEATS_ONE = 9'h001;
   localparam logic [8:0] BEATS_FOUR = 9'h004;
   localparam logic [8:0] BEATS_NOLIMIT = 9'h1FF;
   localparam logic [31:0] STEP_WIDE = 32'h0000_0004;
   localparam logic [31:0] STEP_NARROW = 32'h0000_0002;

   // Access sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_OPEN = 4'b0010,
      ST_BEAT = 4'b0100,
      ST_DONE = 4'b1000
   } sms_state_t;
endpackage

// ==== core/sms_mode_if.sv ====
// Decoded operating mode of one chip-select region
`timescale 1ns/1ps
`default_nettype none
interface sms_mode_if;
   logic [31:0] mode; // Stored mode word
   logic [31:0] addr; // Access address to match
   logic hit; // Address falls in region
   logic [2:0] align; // Split code, reserved folded to none
   logic adv_en; // Drive address valid
   logic wr_four; // Four-beat writes
   logic rd_four; // Four-beat reads
   logic wr_sync; // Clocked writes
   logic rd_sync; // Clocked reads
   logic wide; // 32-bit memory bus
   logic bad_cfg; // Reserved encoding present
   modport src (input mode, input addr, output hit, output align,
      output adv_en, output wr_four, output rd_four, output wr_sync,
      output rd_sync, output wide, output bad_cfg);
   modport dst (output mode, output addr, input hit, input align,
      input adv_en, input wr_four, input rd_four, input wr_sync,
      input rd_sync, input wide, input bad_cfg);
endinterface
`default_nettype wire

// ==== core/sms_region_dec.sv ====
// Address match and field decode for one chip-select region
`timescale 1ns/1ps
`default_nettype none
module sms_region_dec (
   sms_mode_if.src m // Mode word in, decoded fields out
);
   import sms_pkg::*;

   // Raw fields
   wire logic [7:0] base_w = m.mode[BASE_LSB +: 8];
   wire logic [7:0] mask_w = m.mode[MASK_LSB +: 8];
   wire logic [2:0] align_w = m.mode[ALIGN_LSB +: 3];
   wire logic [2:0] wrbl_w = m.mode[WRBL_LSB +: 3];
   wire logic [2:0] rdbl_w = m.mode[RDBL_LSB +: 3];
   wire logic [1:0] width_w = m.mode[WIDTH_LSB +: 2];
   wire logic bad_align = align_w > ALIGN_256;
   wire logic bad_bl = (wrbl_w > BL_FOUR) || (rdbl_w > BL_FOUR);
   wire logic bad_width = (width_w != WIDTH16) && (width_w != WIDTH32);

   // Masked compare of the top address byte
   assign m.hit = ((m.addr[31:24] ^ base_w) & mask_w) == 8'h00;
   // Reserved split codes behave as no split
   assign m.align = bad_align ? ALIGN_NONE : align_w;
   assign m.adv_en = m.mode[ADV_BIT];
   // Reserved burst codes fall back to single beats
   assign m.wr_four = wrbl_w == BL_FOUR;
   assign m.wr_sync = m.mode[WRSYNC_BIT];
   assign m.rd_four = rdbl_w == BL_FOUR;
   assign m.rd_sync = m.mode[RDSYNC_BIT];
   // Only the 16-bit code narrows the bus; reserved stays wide
   assign m.wide = width_w != WIDTH16;
   assign m.bad_cfg = bad_align | bad_bl | bad_width | m.mode[BLS_BIT];
endmodule // sms_region_dec
`default_nettype wire

// ==== core/sms_burst_split.sv ====
// Beats left before the next burst split boundary
`timescale 1ns/1ps
`default_nettype none
module sms_burst_split (
   input wire logic [2:0] align, // Split code, already legal
   input wire logic [8:0] beat_idx, // Beat index of current address
   output logic [8:0] room // Beats before boundary
);
   import sms_pkg::*;

   // Boundary size minus one per code
   wire logic [8:0] span_m1 = (align == ALIGN_32) ? 9'h01F :
                              (align == ALIGN_64) ? 9'h03F :
                              (align == ALIGN_128) ? 9'h07F : 9'h0FF;
   wire logic [8:0] offset = beat_idx & span_m1;
   wire logic [8:0] left = span_m1 - offset + 9'h001;

   // No split lets a burst run as long as asked
   assign room = (align == ALIGN_NONE) ? BEATS_NOLIMIT : left;
endmodule // sms_burst_split
`default_nettype wire

// ==== core/sms_top.sv ====
// Chip-select operating-mode registers with access sequencer
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sms_top #(
   parameter int BOOT_REGION = 0 // Region whose width is strapped
) (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic [7:0] avs_address, // Word address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall the master
   input wire logic [1:0] boot_width_strap, // Boot memory width
   input wire logic acc_valid, // Access request
   input wire logic [31:0] acc_addr, // Access byte address
   input wire logic acc_write, // Access is a write
   input wire logic [8:0] acc_beats, // Beats asked, zero means one
   output logic acc_ready, // Sequencer takes a request
   output logic acc_done, // Access finished, pulse
   output logic acc_miss, // No region matched, pulse
   output logic [1:0] mem_cs_n, // Chip selects, low active
   output logic mem_bls_n, // Byte-lane strobe, low active
   output logic mem_adv_n, // Address valid, low active
   output logic mem_we_n, // Write enable, low active
   output logic mem_oe_n, // Output enable, low active
   output logic [31:0] mem_addr, // Memory byte address
   output logic mem_sync, // Clocked protocol in use
   output logic mem_wide // 32-bit bus in use
);
   import sms_pkg::*;

   // Stored mode words, one per region
   logic [31:0] mode_q [NUM_REGIONS];

   // Per-region decode results
   logic [NUM_REGIONS-1:0] hit_v; // Address matches
   logic [NUM_REGIONS-1:0] adv_v; // Address valid used
   logic [NUM_REGIONS-1:0] wr4_v; // Four-beat writes
   logic [NUM_REGIONS-1:0] rd4_v; // Four-beat reads
   logic [NUM_REGIONS-1:0] wrs_v; // Clocked writes
   logic [NUM_REGIONS-1:0] rds_v; // Clocked reads
   logic [NUM_REGIONS-1:0] wide_v; // 32-bit bus
   logic [NUM_REGIONS-1:0] bad_v; // Reserved code present
   logic [2:0] align_v [NUM_REGIONS]; // Split codes

   // Bus answer registers
   logic wait_q; // Waitrequest flop
   logic [31:0] rdata_q; // Read data flop

   // Sequencer registers
   sms_state_t state_q; // Current state
   logic ready_q; // Request accept flop
   logic done_q; // Completion pulse
   logic miss_q; // Miss pulse
   logic lastmiss_q; // Last request missed
   logic sel_q; // Region of current access
   logic write_q; // Current access direction
   logic [31:0] addr_q; // Next beat address
   logic [8:0] rem_q; // Beats left in access
   logic [8:0] chunk_q; // Beats left in memory burst
   logic [1:0] cs_n_q; // Chip-select pins
   logic bls_n_q; // Byte-lane strobe pin
   logic adv_n_q; // Address valid pin
   logic we_n_q; // Write enable pin
   logic oe_n_q; // Output enable pin
   logic [31:0] maddr_q; // Address pins
   logic sync_q; // Clocked protocol flag
   logic wide_q; // Bus width flag

   // Register decode, word addressed
   wire logic sel_mode1 = avs_address == OFF_MODE_ONE[9:2];
   wire logic sel_mode2 = avs_address == OFF_MODE_TWO[9:2];
   wire logic sel_prog1 = avs_address == OFF_PROG_ONE[9:2];
   wire logic sel_prog2 = avs_address == OFF_PROG_TWO[9:2];
   wire logic sel_stat = avs_address == OFF_STATUS[9:2];
   // A write takes effect on the edge where waitrequest is seen low
   wire logic wr_take = avs_write && !wait_q;
   wire logic busy = state_q != ST_IDLE;

   // Status word: reserved flags, last region, last miss, busy
   wire logic [31:0] status_w = {27'h0000000, bad_v, sel_q,
                                 lastmiss_q, busy};

   // Read data select; unmapped words read as zero
   wire logic [31:0] rd_mux = (sel_mode1 || sel_prog1) ? mode_q[0] :
                              (sel_mode2 || sel_prog2) ? mode_q[1] :
                              sel_stat ? status_w : 32'h0000_0000;

   // One region decoder per chip select
   genvar g;
   generate
      for (g = 0; g < NUM_REGIONS; g = g + 1) begin : g_region
         // Loader offset for this region
         wire logic prog_hit = (g == 0) ? sel_prog1 : sel_prog2;

         sms_mode_if mif ();

         // Region decode runs on the incoming request address
         assign mif.mode = mode_q[g];
         assign mif.addr = acc_addr;
         assign hit_v[g] = mif.hit;
         assign adv_v[g] = mif.adv_en;
         assign wr4_v[g] = mif.wr_four;
         assign rd4_v[g] = mif.rd_four;
         assign wrs_v[g] = mif.wr_sync;
         assign rds_v[g] = mif.rd_sync;
         assign wide_v[g] = mif.wide;
         assign bad_v[g] = mif.bad_cfg;
         assign align_v[g] = mif.align;

         sms_region_dec u_dec (
            .m (mif.src)
         );

         // Mode word store; the bus view at the mode offsets is
         // read-only, so loads arrive through the loader offset
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               if (g == BOOT_REGION) begin
                  // Strap sampled while reset is held
                  mode_q[g] <= {MODE_RESET[31:2], boot_width_strap};
               end else begin
                  mode_q[g] <= MODE_RESET;
               end
            end else if (wr_take && prog_hit) begin
               // Reserved bit kept zero whatever is written
               mode_q[g] <= avs_writedata & ~RSVD_MASK;
            end
         end
      end
   endgenerate

   // Region chosen for a new request; region one wins a tie
   wire logic hit_any = |hit_v;
   wire logic hit_idx = !hit_v[0];

   // Burst sizing for the burst about to open
   wire logic cur_wide = wide_v[sel_q];
   wire logic cur_four = write_q ? wr4_v[sel_q] : rd4_v[sel_q];
   wire logic cur_sync = write_q ? wrs_v[sel_q] : rds_v[sel_q];
   wire logic [8:0] blen = cur_four ? BEATS_FOUR : BEATS_ONE;
   // Beat index counts in units of the memory bus width
   wire logic [8:0] beat_idx = cur_wide ? addr_q[10:2] : addr_q[9:1];
   wire logic [31:0] step = cur_wide ? STEP_WIDE : STEP_NARROW;
   wire logic [31:0] next_addr = addr_q + step;
   wire logic [8:0] room;
   wire logic [8:0] lim = (blen < room) ? blen : room;
   wire logic [8:0] chunk = (rem_q < lim) ? rem_q : lim;
   // Requests of zero beats are served as one
   wire logic [8:0] req_beats = (acc_beats == 9'h000) ? BEATS_ONE :
                                acc_beats;

   // Beats until the boundary of the chosen region
   sms_burst_split u_split (
      .align (align_v[sel_q]),
      .beat_idx (beat_idx),
      .room (room)
   );

   // Bus slave: one wait cycle, then a single answer cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // Held stalled so no read can finish in reset
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if (!wait_q) begin
         // Answer was taken on this edge
         wait_q <= 1'b1;
      end else if (avs_read || avs_write) begin
         // Read data frozen here and held through the answer
         wait_q <= 1'b0;
         rdata_q <= rd_mux;
      end
   end

   // Access sequencer: gap cycle, then one beat per cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= ST_IDLE;
         ready_q <= 1'b0;
         done_q <= 1'b0;
         miss_q <= 1'b0;
         lastmiss_q <= 1'b0;
         sel_q <= 1'b0;
         write_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         rem_q <= 9'h000;
         chunk_q <= 9'h000;
         cs_n_q <= 2'h3;
         bls_n_q <= 1'b1;
         adv_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         maddr_q <= 32'h0000_0000;
         sync_q <= 1'b0;
         wide_q <= 1'b1;
      end else begin
         // Pulses and address valid last one cycle
         done_q <= 1'b0;
         miss_q <= 1'b0;
         adv_n_q <= 1'b1;
         case (state_q)
            ST_IDLE: begin
               ready_q <= 1'b1;
               if (acc_valid && ready_q) begin
                  if (!hit_any) begin
                     // Nothing matched; stay ready for the next one
                     miss_q <= 1'b1;
                     lastmiss_q <= 1'b1;
                  end else begin
                     ready_q <= 1'b0;
                     lastmiss_q <= 1'b0;
                     sel_q <= hit_idx;
                     write_q <= acc_write;
                     addr_q <= acc_addr;
                     rem_q <= req_beats;
                     state_q <= ST_OPEN;
                  end
               end
            end
            ST_OPEN: begin
               // Open a memory burst on the chosen region
               cs_n_q <= sel_q ? 2'h1 : 2'h2;
               // Strobe timing follows chip select
               bls_n_q <= 1'b0;
               adv_n_q <= !adv_v[sel_q];
               we_n_q <= !write_q;
               oe_n_q <= write_q;
               maddr_q <= addr_q;
               sync_q <= cur_sync;
               wide_q <= cur_wide;
               chunk_q <= chunk;
               state_q <= ST_BEAT;
            end
            ST_BEAT: begin
               // One beat completes on every edge
               addr_q <= next_addr;
               maddr_q <= next_addr;
               rem_q <= rem_q - 9'h001;
               chunk_q <= chunk_q - 9'h001;
               if (chunk_q == 9'h001) begin
                  // Burst ends; a split reopens after a gap cycle
                  cs_n_q <= 2'h3;
                  bls_n_q <= 1'b1;
                  we_n_q <= 1'b1;
                  oe_n_q <= 1'b1;
                  state_q <= (rem_q == 9'h001) ? ST_DONE : ST_OPEN;
               end
            end
            ST_DONE: begin
               done_q <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: begin
               // Unknown code recovers to idle with pins released
               cs_n_q <= 2'h3;
               bls_n_q <= 1'b1;
               we_n_q <= 1'b1;
               oe_n_q <= 1'b1;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign acc_ready = ready_q;
   assign acc_done = done_q;
   assign acc_miss = miss_q;
   assign mem_cs_n = cs_n_q;
   assign mem_bls_n = bls_n_q;
   assign mem_adv_n = adv_n_q;
   assign mem_we_n = we_n_q;
   assign mem_oe_n = oe_n_q;
   assign mem_addr = maddr_q;
   assign mem_sync = sync_q;
   assign mem_wide = wide_q;
endmodule // sms_top
`default_nettype wire

// ==== bench/sms_chk.sv ====
// Pin-level checks for the chip-select mode block
`timescale 1ns/1ps
`default_nettype none
module sms_chk (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic avs_read, // Read request
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   input wire logic acc_done, // Done pulse
   input wire logic acc_miss, // Miss pulse
   input wire logic [1:0] mem_cs_n, // Chip selects, low active
   input wire logic mem_bls_n, // Byte-lane strobe, low active
   input wire logic mem_adv_n, // Address valid, low active
   input wire logic mem_we_n, // Write enable, low active
   input wire logic mem_oe_n, // Output enable, low active
   input wire logic [31:0] mem_addr, // Beat address
   input wire logic mem_wide // 32-bit bus in use
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   wire cs_on = mem_cs_n != 2'b11; // Some region selected

   // Reset must stall reads, so no stale word leaks out
   chk_reset_stall: assert property (disable iff (1'b0) reset |=>
      avs_waitrequest && avs_readdata == 32'h0) else $error("reset read");
   chk_read_answer: assert property ($rose(avs_read) |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("read answer");
   chk_one_region: assert property (mem_cs_n != 2'b00)
      else $error("two regions");
   // Strobe timing is tied to chip select in every mode
   chk_bls_follow: assert property (mem_bls_n == !cs_on)
      else $error("strobe timing");
   chk_miss_quiet: assert property (acc_miss |-> !cs_on ##1 !cs_on)
      else $error("miss selected");
   chk_adv_first: assert property (!mem_adv_n |->
      cs_on && $past(mem_cs_n) == 2'b11) else $error("adv timing");
   chk_burst_max: assert property (cs_on [*4] |=> !cs_on)
      else $error("burst too long");
   chk_dir_excl: assert property (!mem_we_n || !mem_oe_n |->
      cs_on && mem_we_n != mem_oe_n) else $error("strobe mix");
   chk_addr_step: assert property (cs_on && mem_cs_n == $past(mem_cs_n)
      |-> mem_addr == $past(mem_addr) + (mem_wide ? 32'h4 : 32'h2))
      else $error("address step");
   chk_done_after: assert property (acc_done |->
      !cs_on && $past(mem_cs_n, 2) != 2'b11) else $error("early done");

   // Main scenarios reached
   cov_miss: cover property (acc_miss);
   cov_four: cover property (cs_on [*4]);
   cov_read: cover property (avs_read && !avs_waitrequest);
endmodule // sms_chk
`default_nettype wire

// ==== bench/sms_mem_model.sv ====
// Observer model of the static memory behind the chip selects
`timescale 1ns/1ps
`default_nettype none
module sms_mem_model (
   input wire logic clk_sys, // System clock
   input wire logic clr, // Clear the tallies
   input wire logic [1:0] mem_cs_n, // Chip selects, low active
   input wire logic mem_adv_n, // Address valid, low active
   input wire logic [31:0] mem_addr, // Beat address
   input wire logic mem_sync, // Clocked protocol
   input wire logic mem_wide, // 32-bit bus
   output logic [7:0] bursts, // Bursts seen
   output logic [7:0] first_len, // Beats in first burst
   output logic [7:0] advs, // Address valid strobes
   output logic [1:0] cs_seen, // Last region selected
   output logic sync_seen, // Last protocol seen
   output logic wide_seen, // Last width seen
   output logic [31:0] step // Address step inside a burst
);
   logic [1:0] prev_cs_q; // Selects one cycle back
   logic [31:0] prev_addr_q; // Address one cycle back
   wire sel = mem_cs_n != 2'b11; // Memory selected
   wire opening = prev_cs_q == 2'b11; // First beat of a burst

   // Tally every beat; data lines are not modelled
   always_ff @(posedge clk_sys) begin
      prev_cs_q <= mem_cs_n;
      prev_addr_q <= mem_addr;
      if (clr) begin
         bursts <= 8'h0;
         first_len <= 8'h0;
         advs <= 8'h0;
         cs_seen <= 2'b11;
         sync_seen <= 1'b0;
         wide_seen <= 1'b0;
         step <= 32'h0;
      end else if (sel) begin
         cs_seen <= mem_cs_n;
         sync_seen <= mem_sync;
         wide_seen <= mem_wide;
         if (!mem_adv_n) advs <= advs + 8'h1;
         if (opening) bursts <= bursts + 8'h1;
         else step <= mem_addr - prev_addr_q;
         // Only beats of the first burst count here
         if (bursts == 8'h0 || (bursts == 8'h1 && !opening))
            first_len <= first_len + 8'h1;
      end
   end
endmodule // sms_mem_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Bench for the chip-select mode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sms_pkg::*;
   logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, clr;
   logic acc_valid, acc_write, acc_ready, acc_done, acc_miss, missed;
   logic mem_bls_n, mem_adv_n, mem_we_n, mem_oe_n, mem_sync, mem_wide;
   logic sync_seen, wide_seen, spl;
   logic [7:0] avs_address, bursts, first_len, advs;
   logic [31:0] avs_writedata, avs_readdata, acc_addr, mem_addr, rd, step;
   logic [31:0] w1, w2;
   logic [1:0] boot_width_strap, mem_cs_n, cs_seen;
   logic [8:0] acc_beats;
   int error_cnt, cmp_count;

   sms_top #(.BOOT_REGION(0)) uut (.clk_sys, .reset, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .boot_width_strap, .acc_valid, .acc_addr,
      .acc_write, .acc_beats, .acc_ready, .acc_done, .acc_miss, .mem_cs_n,
      .mem_bls_n, .mem_adv_n, .mem_we_n, .mem_oe_n, .mem_addr, .mem_sync,
      .mem_wide);
   sms_mem_model mem (.clk_sys, .clr, .mem_cs_n, .mem_adv_n, .mem_addr,
      .mem_sync, .mem_wide, .bursts, .first_len, .advs, .cs_seen,
      .sync_seen, .wide_seen, .step);

   // 20 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [9:0] off,
      input logic [31:0] wd);
      int n;
      n = 0;
      avs_address <= off[9:2];
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= wd;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) error_cnt++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   // One memory access; partner tallies cleared until it is taken
   task automatic acc(input logic [31:0] a, input logic wr,
      input logic [8:0] nb);
      int n;
      n = 0;
      missed = 1'b0;
      clr <= 1'b1;
      acc_valid <= 1'b1;
      acc_addr <= a;
      acc_write <= wr;
      acc_beats <= nb;
      do begin
         @(posedge clk_sys);
         n++;
      end while (acc_ready !== 1'b1 && n < 100);
      clr <= 1'b0;
      acc_valid <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
         if (acc_miss === 1'b1) missed = 1'b1;
      end while (acc_done !== 1'b1 && acc_miss !== 1'b1 && n < 2000);
      if (n >= 2000) error_cnt++;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic look(input logic [31:0] exp);
      check("memory view", {missed, sync_seen, wide_seen, 3'h0, cs_seen,
         bursts, first_len, advs}, exp);
   endtask

   // Mode word; reserved bit always written as zero
   function automatic logic [31:0] mk(input logic [7:0] b, m,
      input logic [2:0] al, input logic adv, input logic [2:0] wb,
      input logic ws, input logic [2:0] rb, input logic rs,
      input logic [1:0] w);
      return {b, m, al, 1'b0, adv, 1'b0, wb, ws, rb, rs, w};
   endfunction

   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      report_and_stop;
   end

   initial begin
      {reset, clr, acc_valid, acc_write, missed} = 5'b10000;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {acc_addr, acc_beats} = '0;
      boot_width_strap = WIDTH16;
      error_cnt = 0;
      cmp_count = 0;
      @(posedge clk_sys);
      avs_address <= OFF_MODE_ONE[9:2];
      avs_read <= 1'b1;
      repeat (2) begin
         @(posedge clk_sys);
         check("stall", {31'h0, avs_waitrequest}, 32'h1);
      end
      @(posedge clk_sys);
      reset <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
      // Reset words, strapped width, read-only and unmapped places
      bus(1'b0, OFF_MODE_ONE, 32'h0);
      check("mode one", rd, {MODE_RESET[31:2], WIDTH16});
      bus(1'b0, OFF_MODE_TWO, 32'h0);
      check("mode two", rd, MODE_RESET);
      bus(1'b1, OFF_MODE_ONE, 32'hFFFF_FBFF);
      bus(1'b0, OFF_MODE_ONE, 32'h0);
      check("read only", rd, {MODE_RESET[31:2], WIDTH16});
      bus(1'b0, 10'h3F0, 32'h0);
      check("unmapped", rd, 32'h0);
      w1 = mk(8'h10, 8'hFF, ALIGN_NONE, 1'b1, BL_ONE, 1'b0, BL_FOUR, 1'b1,
         WIDTH16);
      w2 = mk(8'h20, 8'hF0, ALIGN_NONE, 1'b0, BL_FOUR, 1'b1, BL_ONE, 1'b0,
         WIDTH32);
      bus(1'b1, OFF_PROG_ONE, w1);
      bus(1'b1, OFF_PROG_TWO, w2);
      bus(1'b0, OFF_MODE_ONE, 32'h0);
      check("mode one set", rd, w1);
      bus(1'b0, OFF_MODE_TWO, 32'h0);
      check("mode two set", rd, w2);
      // Burst lengths, protocols, widths and matching
      acc(32'h1000_0000, 1'b0, 9'd8);
      look({3'b010, 3'h0, 2'b10, 8'd2, 8'd4, 8'd2});
      check("narrow step", step, STEP_NARROW);
      acc(32'h10FF_FF00, 1'b1, 9'd3);
      look({3'b000, 3'h0, 2'b10, 8'd3, 8'd1, 8'd3});
      acc(32'h2A00_0040, 1'b1, 9'd4);
      look({3'b011, 3'h0, 2'b01, 8'd1, 8'd4, 8'd0});
      check("wide step", step, STEP_WIDE);
      acc(32'h2300_0000, 1'b0, 9'd2);
      look({3'b001, 3'h0, 2'b01, 8'd2, 8'd1, 8'd0});
      acc(32'h1100_0000, 1'b0, 9'd1);
      look({3'b100, 3'h0, 2'b11, 24'h0});
      acc(32'h3A00_0000, 1'b0, 9'd1);
      look({3'b100, 3'h0, 2'b11, 24'h0});
      // Status: last hit in region two, last request missed, idle
      bus(1'b0, OFF_STATUS, 32'h0);
      check("status miss", rd, 32'h0000_0006);
      // Split codes 0 to 5, two beats short of its boundary
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, OFF_PROG_ONE, mk(8'h10, 8'hFF, k[2:0], 1'b1, BL_ONE,
            1'b0, BL_FOUR, 1'b0, WIDTH32));
         acc(32'h1000_0000 + ((32'd16 << k) - 32'd2) * 32'd4, 1'b0, 9'd4);
         spl = k >= 1 && k <= 4;
         look({3'b001, 3'h0, 2'b10, spl ? 8'd2 : 8'd1,
            spl ? 8'd2 : 8'd4, spl ? 8'd2 : 8'd1});
      end
      // Last split code was reserved: region one flagged in status
      bus(1'b0, OFF_STATUS, 32'h0);
      check("status flag", rd, 32'h0000_0008);
      report_and_stop;
   end
endmodule // tb_top

bind sms_top sms_chk u_chk (.clk_sys, .reset, .avs_read, .avs_readdata,
   .avs_waitrequest, .acc_done, .acc_miss, .mem_cs_n, .mem_bls_n, .mem_adv_n,
   .mem_we_n, .mem_oe_n, .mem_addr, .mem_wide);
`default_nettype wire
